//--- spi_irq_pkg.sv
// constants for the spi interrupt flag and data buffer block
package spi_irq_pkg;

	// register bus geometry
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;

	// register offsets
	localparam logic [2:0] OFF_CTRL_A = 3'h0; // enable and master role
	localparam logic [2:0] OFF_CTRL_B = 3'h1; // buffered mode and select disable
	localparam logic [2:0] OFF_IRQ_EN = 3'h2; // spi_interrupt_enable
	localparam logic [2:0] OFF_IRQ_FLAGS = 3'h3; // spi_interrupt_flags
	localparam logic [2:0] OFF_DATA = 3'h4; // spi_data

	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] READ_ZERO = 8'h00;

	// control field positions
	localparam int BIT_ENABLE = 0;
	localparam int BIT_MASTER = 5;
	localparam int BIT_BUFFERED = 7;
	localparam int BIT_SEL_DIS = 2;

	// interrupt enable field positions
	localparam int BIT_RX_DONE_EN = 7;
	localparam int BIT_TX_DONE_EN = 6;
	localparam int BIT_TX_EMPTY_EN = 5;
	localparam int BIT_SEL_TRIG_EN = 4;
	localparam int BIT_UNBUF_EN = 0;

	// interrupt flag field positions
	localparam int BIT_RX_DONE = 7; // also the unbuffered combined flag
	localparam int BIT_TX_DONE = 6; // also the write collision flag
	localparam int BIT_TX_EMPTY = 5;
	localparam int BIT_SEL_TRIG = 4;
	localparam int BIT_OVF = 0;

	// shifter bit count and receive buffer fill counts
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [1:0] RX_EMPTY = 2'h0;
	localparam logic [1:0] RX_ONE = 2'h1;
	localparam logic [1:0] RX_FULL = 2'h2;

	// master shifter states, gray along idle-lead-trail
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LEAD = 2'b01,
		ST_TRAIL = 2'b11
	} shift_state_t;

endpackage

//--- spi_irq_buffer.sv
// spi interrupt enables, flags, data register and two-deep receive buffer
module spi_irq_buffer #(
	parameter int HALF_DIV = 2, // core cycles per sck half period in master role
	parameter int DIV_W = 8 // width of the sck divider counter
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [spi_irq_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [spi_irq_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [spi_irq_pkg::DATA_W-1:0] reg_rdata,
	input wire logic irq_ack,
	output logic irq,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe,
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe,
	input wire logic sel_n_in
);

	// refuse divider values the counter cannot hold
	generate
		if (HALF_DIV < 1 || HALF_DIV >= (1 << DIV_W)) begin : g_bad_div
			$error("HALF_DIV out of range for DIV_W");
		end
	endgenerate

	localparam logic [DIV_W-1:0] DIV_END = DIV_W'(HALF_DIV - 1); // last divider count

	// address match used by every strobe decode
	function automatic logic hit(input logic [spi_irq_pkg::ADDR_W-1:0] a,
		input logic [spi_irq_pkg::ADDR_W-1:0] off);
		hit = (a == off);
	endfunction

	// pin synchronisers, second stage plus edge history
	logic sck_m_ff, sck_s_ff, sck_d_ff;
	logic mosi_m_ff, mosi_s_ff;
	logic miso_m_ff, miso_s_ff;
	logic sel_m_ff, sel_s_ff;

	// control state
	logic enable_ff; // block enable
	logic master_ff; // master role
	logic buffered_mode_on_ff; // buffered operation
	logic sel_disable_ff; // select line ignored in master role
	logic [7:0] irq_en_ff; // spi_interrupt_enable storage

	// shifter
	spi_irq_pkg::shift_state_t state_ff;
	logic [DIV_W-1:0] div_ff; // half period counter
	logic [2:0] bit_cnt_ff; // bits done in current byte
	logic [7:0] shift_ff; // shift register
	logic sck_out_ff, sck_oe_ff, mosi_out_ff, mosi_oe_ff, miso_out_ff, miso_oe_ff;

	// buffers
	logic [7:0] tx_buf_ff; // transmit buffer stage
	logic tx_full_ff; // transmit buffer holds a byte
	logic [7:0] rx1_ff; // first receive stage, newest
	logic [7:0] rx2_ff; // second receive stage, oldest
	logic [1:0] rx_cnt_ff; // unread bytes

	// flags
	logic rx_done_flag_ff, tx_done_flag_ff, tx_empty_flag_ff;
	logic sel_trigger_flag_ff, rx_overflow_flag_ff, ovf_pend_ff;
	logic comb_flag_ff, write_collision_flag_ff;
	logic arm_comb_ff, arm_wcol_ff; // flags read while set, awaiting data access
	logic [7:0] rdata_ff;
	logic irq_ff;

	// decoded strobes
	logic data_wr, data_rd, data_acc, flags_rd, flags_wr;
	logic busy, load_go, wcol_evt, sel_evt, slave_on, slave_rise, done_evt, xfer_start;
	logic pop, push, ovf_evt, nxt_tx_full;
	logic [7:0] load_byte, rx_byte, en_view, flag_view;
	logic [3:0] w1c;

	// bus strobe decode
	always_comb begin
		data_wr = reg_wr && hit(reg_addr, spi_irq_pkg::OFF_DATA);
		data_rd = reg_rd && hit(reg_addr, spi_irq_pkg::OFF_DATA);
		data_acc = data_wr || data_rd;
		flags_rd = reg_rd && hit(reg_addr, spi_irq_pkg::OFF_IRQ_FLAGS);
		flags_wr = reg_wr && hit(reg_addr, spi_irq_pkg::OFF_IRQ_FLAGS);
		// write one clears, zero keeps; overflow bit is not cleared by a write
		w1c[3] = flags_wr && buffered_mode_on_ff && reg_wdata[spi_irq_pkg::BIT_RX_DONE];
		w1c[2] = flags_wr && buffered_mode_on_ff && reg_wdata[spi_irq_pkg::BIT_TX_DONE];
		w1c[1] = flags_wr && buffered_mode_on_ff && reg_wdata[spi_irq_pkg::BIT_SEL_TRIG];
		w1c[0] = 1'b0;
	end

	// shifter status and events
	always_comb begin
		busy = (state_ff != spi_irq_pkg::ST_IDLE) || (bit_cnt_ff != 3'h0);
		slave_on = enable_ff && !master_ff && !sel_s_ff;
		slave_rise = slave_on && sck_s_ff && !sck_d_ff;
		// select pulled low while master and not disabled
		sel_evt = enable_ff && master_ff && !sel_s_ff && !sel_disable_ff;
		// unbuffered writes load directly, buffered ones go through the stage
		if (buffered_mode_on_ff) begin
			load_go = enable_ff && tx_full_ff && !busy && !sel_evt;
			load_byte = tx_buf_ff;
		end else begin
			load_go = enable_ff && data_wr && !busy && !sel_evt;
			load_byte = reg_wdata;
		end
		wcol_evt = !buffered_mode_on_ff && data_wr && busy;
		if (master_ff) begin
			done_evt = enable_ff && !sel_evt && (state_ff == spi_irq_pkg::ST_TRAIL)
				&& (div_ff == DIV_END) && (bit_cnt_ff == spi_irq_pkg::LAST_BIT);
			rx_byte = shift_ff;
		end else begin
			done_evt = slave_rise && (bit_cnt_ff == spi_irq_pkg::LAST_BIT);
			rx_byte = {shift_ff[6:0], mosi_s_ff};
		end
		xfer_start = (load_go && master_ff) || (slave_rise && (bit_cnt_ff == 3'h0));
		// receive stage movement
		pop = buffered_mode_on_ff && data_rd && (rx_cnt_ff != spi_irq_pkg::RX_EMPTY);
		push = buffered_mode_on_ff && done_evt && ((rx_cnt_ff != spi_irq_pkg::RX_FULL) || pop);
		ovf_evt = buffered_mode_on_ff && done_evt && (rx_cnt_ff == spi_irq_pkg::RX_FULL)
			&& !pop;
		// a new write beats the move to the shifter
		nxt_tx_full = (buffered_mode_on_ff && data_wr) || (tx_full_ff && !load_go);
	end

	// two flip-flop synchronisers for all link pins
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sck_m_ff <= 1'b0;
			sck_s_ff <= 1'b0;
			sck_d_ff <= 1'b0;
			mosi_m_ff <= 1'b0;
			mosi_s_ff <= 1'b0;
			miso_m_ff <= 1'b0;
			miso_s_ff <= 1'b0;
			sel_m_ff <= 1'b1;
			sel_s_ff <= 1'b1;
		end else begin
			sck_m_ff <= sck_in;
			sck_s_ff <= sck_m_ff;
			sck_d_ff <= sck_s_ff; // edge history
			mosi_m_ff <= mosi_in;
			mosi_s_ff <= mosi_m_ff;
			miso_m_ff <= miso_in;
			miso_s_ff <= miso_m_ff;
			sel_m_ff <= sel_n_in;
			sel_s_ff <= sel_m_ff;
		end
	end

	// control and enable registers
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			enable_ff <= 1'b0;
			master_ff <= 1'b0;
			buffered_mode_on_ff <= 1'b0;
			sel_disable_ff <= 1'b0;
			irq_en_ff <= spi_irq_pkg::RST_BYTE;
		end else begin
			if (reg_wr && hit(reg_addr, spi_irq_pkg::OFF_CTRL_A)) begin
				enable_ff <= reg_wdata[spi_irq_pkg::BIT_ENABLE];
			end
			// fall-back to slave wins over a master write in the same cycle
			if (sel_evt) begin
				master_ff <= 1'b0;
			end else if (reg_wr && hit(reg_addr, spi_irq_pkg::OFF_CTRL_A)) begin
				master_ff <= reg_wdata[spi_irq_pkg::BIT_MASTER];
			end
			if (reg_wr && hit(reg_addr, spi_irq_pkg::OFF_CTRL_B)) begin
				buffered_mode_on_ff <= reg_wdata[spi_irq_pkg::BIT_BUFFERED];
				sel_disable_ff <= reg_wdata[spi_irq_pkg::BIT_SEL_DIS];
			end
			if (reg_wr && hit(reg_addr, spi_irq_pkg::OFF_IRQ_EN)) begin
				irq_en_ff <= reg_wdata;
			end
		end
	end

	// shift engine, mode 0, msb first
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_ff <= spi_irq_pkg::ST_IDLE;
			div_ff <= '0;
			bit_cnt_ff <= 3'h0;
			shift_ff <= spi_irq_pkg::RST_BYTE;
			sck_out_ff <= 1'b0;
			mosi_out_ff <= 1'b0;
			miso_out_ff <= 1'b0;
			sck_oe_ff <= 1'b0;
			mosi_oe_ff <= 1'b0;
			miso_oe_ff <= 1'b0;
		end else begin
			sck_oe_ff <= enable_ff && master_ff && !sel_evt;
			mosi_oe_ff <= enable_ff && master_ff && !sel_evt;
			miso_oe_ff <= slave_on;
			if (sel_evt) begin
				// abort the master byte on fall-back
				state_ff <= spi_irq_pkg::ST_IDLE;
				bit_cnt_ff <= 3'h0;
				div_ff <= '0;
				sck_out_ff <= 1'b0;
			end else if (enable_ff && master_ff) begin
				case (state_ff)
					spi_irq_pkg::ST_IDLE: begin
						if (load_go) begin
							shift_ff <= load_byte;
							mosi_out_ff <= load_byte[7];
							div_ff <= '0;
							state_ff <= spi_irq_pkg::ST_LEAD;
						end
					end
					spi_irq_pkg::ST_LEAD: begin
						if (div_ff == DIV_END) begin
							// rising edge: sample the peer
							div_ff <= '0;
							sck_out_ff <= 1'b1;
							shift_ff <= {shift_ff[6:0], miso_s_ff};
							state_ff <= spi_irq_pkg::ST_TRAIL;
						end else begin
							div_ff <= div_ff + 1'b1;
						end
					end
					spi_irq_pkg::ST_TRAIL: begin
						if (div_ff == DIV_END) begin
							// falling edge: next bit out or byte done
							div_ff <= '0;
							sck_out_ff <= 1'b0;
							bit_cnt_ff <= bit_cnt_ff + 1'b1;
							if (bit_cnt_ff == spi_irq_pkg::LAST_BIT) begin
								state_ff <= spi_irq_pkg::ST_IDLE;
							end else begin
								mosi_out_ff <= shift_ff[7];
								state_ff <= spi_irq_pkg::ST_LEAD;
							end
						end else begin
							div_ff <= div_ff + 1'b1;
						end
					end
					default: begin
						state_ff <= spi_irq_pkg::ST_IDLE;
					end
				endcase
			end else begin
				// slave role or disabled
				state_ff <= spi_irq_pkg::ST_IDLE;
				sck_out_ff <= 1'b0;
				if (!slave_on) begin
					bit_cnt_ff <= 3'h0; // deselect ends any partial byte
				end else if (slave_rise) begin
					bit_cnt_ff <= bit_cnt_ff + 1'b1;
				end
				if (slave_rise) begin
					shift_ff <= rx_byte;
					miso_out_ff <= shift_ff[6];
				end else if (load_go) begin
					shift_ff <= load_byte;
					miso_out_ff <= load_byte[7];
				end else begin
					miso_out_ff <= shift_ff[7];
				end
			end
		end
	end

	// transmit buffer stage
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			tx_buf_ff <= spi_irq_pkg::RST_BYTE;
			tx_full_ff <= 1'b0;
			tx_empty_flag_ff <= 1'b0;
		end else begin
			if (buffered_mode_on_ff && data_wr) begin
				tx_buf_ff <= reg_wdata;
			end
			tx_full_ff <= nxt_tx_full;
			// high only while the stage is empty; a data write drops it
			tx_empty_flag_ff <= buffered_mode_on_ff && !nxt_tx_full;
		end
	end

	// receive stages, stage two is the oldest byte
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rx1_ff <= spi_irq_pkg::RST_BYTE;
			rx2_ff <= spi_irq_pkg::RST_BYTE;
			rx_cnt_ff <= spi_irq_pkg::RX_EMPTY;
		end else if (!buffered_mode_on_ff) begin
			rx_cnt_ff <= spi_irq_pkg::RX_EMPTY;
			if (done_evt) begin
				rx2_ff <= rx_byte; // single holding register
			end
		end else begin
			if (pop && (rx_cnt_ff == spi_irq_pkg::RX_FULL)) begin
				rx2_ff <= rx1_ff;
			end
			if (push) begin
				if ((rx_cnt_ff - {1'b0, pop}) == spi_irq_pkg::RX_EMPTY) begin
					rx2_ff <= rx_byte;
				end else begin
					rx1_ff <= rx_byte;
				end
			end
			rx_cnt_ff <= rx_cnt_ff - {1'b0, pop} + {1'b0, push};
		end
	end

	// buffered mode flags, set beats clear
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rx_done_flag_ff <= 1'b0;
			tx_done_flag_ff <= 1'b0;
			sel_trigger_flag_ff <= 1'b0;
			rx_overflow_flag_ff <= 1'b0;
			ovf_pend_ff <= 1'b0;
		end else begin
			rx_done_flag_ff <= push || (rx_done_flag_ff && !w1c[3]
				&& !(pop && (rx_cnt_ff == spi_irq_pkg::RX_ONE)));
			tx_done_flag_ff <= (buffered_mode_on_ff && done_evt && !tx_full_ff)
				|| (tx_done_flag_ff && !w1c[2]);
			sel_trigger_flag_ff <= (buffered_mode_on_ff && sel_evt)
				|| (sel_trigger_flag_ff && !w1c[1]);
			// with nothing to send the overflow waits for the next transfer
			ovf_pend_ff <= (ovf_evt && !tx_full_ff)
				|| (ovf_pend_ff && !xfer_start && !data_rd);
			rx_overflow_flag_ff <= (ovf_evt && tx_full_ff) || (ovf_pend_ff && xfer_start)
				|| (rx_overflow_flag_ff && !data_rd);
		end
	end

	// unbuffered flags: combined cleared by vector or flags read then data access, collision only by flags read then data access
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			comb_flag_ff <= 1'b0;
			write_collision_flag_ff <= 1'b0;
			arm_comb_ff <= 1'b0;
			arm_wcol_ff <= 1'b0;
		end else begin
			comb_flag_ff <= (!buffered_mode_on_ff && (done_evt || sel_evt))
				|| (comb_flag_ff && !irq_ack && !(arm_comb_ff && data_acc));
			write_collision_flag_ff <= wcol_evt
				|| (write_collision_flag_ff && !(arm_wcol_ff && data_acc));
			arm_comb_ff <= (flags_rd && comb_flag_ff && !buffered_mode_on_ff)
				|| (arm_comb_ff && !data_acc);
			arm_wcol_ff <= (flags_rd && write_collision_flag_ff && !buffered_mode_on_ff)
				|| (arm_wcol_ff && !data_acc);
		end
	end

	// enable and flag views as software sees them
	always_comb begin
		en_view = spi_irq_pkg::READ_ZERO;
		flag_view = spi_irq_pkg::READ_ZERO;
		en_view[spi_irq_pkg::BIT_UNBUF_EN] = irq_en_ff[spi_irq_pkg::BIT_UNBUF_EN];
		if (buffered_mode_on_ff) begin
			en_view[spi_irq_pkg::BIT_RX_DONE_EN] = irq_en_ff[spi_irq_pkg::BIT_RX_DONE_EN];
			en_view[spi_irq_pkg::BIT_TX_DONE_EN] = irq_en_ff[spi_irq_pkg::BIT_TX_DONE_EN];
			en_view[spi_irq_pkg::BIT_TX_EMPTY_EN] = irq_en_ff[spi_irq_pkg::BIT_TX_EMPTY_EN];
			en_view[spi_irq_pkg::BIT_SEL_TRIG_EN] = irq_en_ff[spi_irq_pkg::BIT_SEL_TRIG_EN];
			flag_view[spi_irq_pkg::BIT_RX_DONE] = rx_done_flag_ff;
			flag_view[spi_irq_pkg::BIT_TX_DONE] = tx_done_flag_ff;
			flag_view[spi_irq_pkg::BIT_TX_EMPTY] = tx_empty_flag_ff;
			flag_view[spi_irq_pkg::BIT_SEL_TRIG] = sel_trigger_flag_ff;
			flag_view[spi_irq_pkg::BIT_OVF] = rx_overflow_flag_ff;
		end else begin
			flag_view[spi_irq_pkg::BIT_RX_DONE] = comb_flag_ff;
			flag_view[spi_irq_pkg::BIT_TX_DONE] = write_collision_flag_ff;
		end
	end

	// read data, valid the cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rdata_ff <= spi_irq_pkg::READ_ZERO;
		end else if (!reg_rd) begin
			rdata_ff <= spi_irq_pkg::READ_ZERO;
		end else if (hit(reg_addr, spi_irq_pkg::OFF_CTRL_A)) begin
			rdata_ff <= spi_irq_pkg::READ_ZERO;
			rdata_ff[spi_irq_pkg::BIT_ENABLE] <= enable_ff;
			rdata_ff[spi_irq_pkg::BIT_MASTER] <= master_ff;
		end else if (hit(reg_addr, spi_irq_pkg::OFF_CTRL_B)) begin
			rdata_ff <= spi_irq_pkg::READ_ZERO;
			rdata_ff[spi_irq_pkg::BIT_BUFFERED] <= buffered_mode_on_ff;
			rdata_ff[spi_irq_pkg::BIT_SEL_DIS] <= sel_disable_ff;
		end else if (hit(reg_addr, spi_irq_pkg::OFF_IRQ_EN)) begin
			rdata_ff <= en_view;
		end else if (hit(reg_addr, spi_irq_pkg::OFF_IRQ_FLAGS)) begin
			rdata_ff <= flag_view;
		end else if (hit(reg_addr, spi_irq_pkg::OFF_DATA)) begin
			rdata_ff <= rx2_ff;
		end else begin
			rdata_ff <= spi_irq_pkg::READ_ZERO; // unmapped
		end
	end

	// interrupt request, held while any enabled flag is set
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			irq_ff <= 1'b0;
		end else if (buffered_mode_on_ff) begin
			irq_ff <= |(en_view[7:4] & flag_view[7:4]);
		end else begin
			irq_ff <= en_view[spi_irq_pkg::BIT_UNBUF_EN] && comb_flag_ff;
		end
	end

	// outputs straight from flip-flops
	assign reg_rdata = rdata_ff;
	assign irq = irq_ff;
	assign sck_out = sck_out_ff;
	assign sck_oe = sck_oe_ff;
	assign mosi_out = mosi_out_ff;
	assign mosi_oe = mosi_oe_ff;
	assign miso_out = miso_out_ff;
	assign miso_oe = miso_oe_ff;

endmodule

//--- spi_irq_buffer_assertions.sv
// port-level checker for the spi interrupt flag and data buffer block
module spi_irq_buffer_chk #(
	parameter int HALF_DIV = 2, // core cycles per sck half period
	parameter int DIV_W = 8 // width of the run counter
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic irq_ack,
	input wire logic irq,
	input wire logic sck_out,
	input wire logic sck_oe,
	input wire logic mosi_out,
	input wire logic miso_oe,
	input wire logic sel_n_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic buf_ff; // buffered mode shadow
	logic sel_dis_ff; // select disable shadow
	logic [7:0] en_ff; // enable register shadow
	logic [DIV_W-1:0] hi_ff; // cycles sck has been high
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// shadows of the control writes
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			buf_ff <= 1'b0;
			sel_dis_ff <= 1'b0;
			en_ff <= 8'h00;
		end else if (reg_wr && reg_addr == spi_irq_pkg::OFF_CTRL_B) begin
			buf_ff <= reg_wdata[spi_irq_pkg::BIT_BUFFERED];
			sel_dis_ff <= reg_wdata[spi_irq_pkg::BIT_SEL_DIS];
		end else if (reg_wr && reg_addr == spi_irq_pkg::OFF_IRQ_EN) begin
			en_ff <= reg_wdata & 8'hF1;
		end
	end
	// length of the present sck high phase
	always_ff @(posedge core_clk) begin
		if (!rst_n || !sck_out) begin
			hi_ff <= '0;
		end else begin
			hi_ff <= hi_ff + 1'b1;
		end
	end
	en_read_a: assert property (
		reg_rd && reg_addr == spi_irq_pkg::OFF_IRQ_EN |=>
		reg_rdata == (buf_ff ? en_ff : (en_ff & 8'h01))) else $error("enable readback wrong");
	flags_unbuf_a: assert property (
		reg_rd && reg_addr == spi_irq_pkg::OFF_IRQ_FLAGS && !buf_ff |=>
		reg_rdata[5:0] == 6'h00) else $error("unbuffered flag bits not zero");
	irq_gated_a: assert property ($past(en_ff) == 8'h00 |-> !irq)
		else $error("irq with all enables off");
	irq_ack_a: assert property (irq_ack && !buf_ff |-> ##2 !irq)
		else $error("irq stays after vector");
	sck_high_a: assert property ($fell(sck_out) |-> hi_ff == HALF_DIV[DIV_W-1:0])
		else $error("sck high phase length wrong");
	mosi_hold_a: assert property (sck_out && $past(sck_out) |-> $stable(mosi_out))
		else $error("mosi moved while sck high");
	sel_drop_a: assert property ((!sel_n_in && !sel_dis_ff) [*6] |-> !sck_oe)
		else $error("master kept with select low");
	oe_excl_a: assert property (!(sck_oe && miso_oe))
		else $error("master and slave drive at once");
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its cycle");
	cover property ($rose(irq));
	cover property ($rose(miso_oe));
	cover property ($fell(sck_oe));
	cover property (irq_ack && irq);
endmodule

bind spi_irq_buffer spi_irq_buffer_chk #(.HALF_DIV(HALF_DIV), .DIV_W(DIV_W)) u_chk (
	.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.irq_ack, .irq, .sck_out, .sck_oe, .mosi_out, .miso_oe, .sel_n_in
);

//--- spi_peer.sv
// behavioural spi peer: slave to the block's master, master to its slave
module spi_peer (
	input wire logic dut_sck,
	input wire logic dut_sck_oe,
	input wire logic dut_mosi,
	input wire logic dut_miso,
	output logic miso,
	output logic sck,
	output logic mosi,
	output logic sel_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] tx_sh; // reply going back
	logic [7:0] rx_sh; // byte taken in
	logic [7:0] sl_rx; // byte taken from the block in its slave role
	int n_bits; // rising edges in this byte
	initial begin
		tx_sh = 8'h00;
		rx_sh = 8'h00;
		sl_rx = 8'h00;
		n_bits = 0;
		sck = 1'b0;
		mosi = 1'b1;
		sel_n = 1'b1;
	end
	// released line shows the inverse of its last bit
	assign miso = dut_sck_oe ? tx_sh[7] : ~tx_sh[7];
	// mode 0 sample on rise
	always @(posedge dut_sck) begin
		rx_sh = {rx_sh[6:0], dut_mosi};
		n_bits = n_bits + 1;
	end
	// next bit on fall; after a byte the reply is its inverse
	always @(negedge dut_sck) begin
		if (n_bits == 8) begin
			tx_sh = ~rx_sh;
			n_bits = 0;
		end else begin
			tx_sh = tx_sh << 1;
		end
	end
	// preset the first reply
	task automatic load(input logic [7:0] b);
		tx_sh = b;
		n_bits = 0;
	endtask
	// drive the select line
	task automatic set_sel(input logic v);
		sel_n <= v; // after the edge, never racing the block's sampling
	endtask
	// one byte as master, 400 ns sck period, edges kept off the core clock edges
	task automatic send(input logic [7:0] b);
		#10 sel_n = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			mosi = b[i];
			#200 sck = 1'b1;
			sl_rx = {sl_rx[6:0], dut_miso};
			#200 sck = 1'b0;
		end
		mosi = ~b[0];
		#200 sel_n = 1'b1;
	endtask
endmodule

//--- spi_irq_buffer_test.sv
// self-checking bench for the spi interrupt flag and data buffer block
module spi_irq_buffer_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HD = 4; // 400 ns sck
	localparam int BYTE = 16 * HD + 8; // one byte plus margin
	typedef struct packed {logic [7:0] b; logic [7:0] w; logic [7:0] e;} row_t;
	row_t rows [5] = '{'{8'h80, 8'hF1, 8'hF1}, '{8'h00, 8'hF1, 8'h01},
		'{8'h80, 8'h90, 8'h90}, '{8'h00, 8'h30, 8'h00}, '{8'h80, 8'h01, 8'h01}};
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic irq_ack = 1'b0;
	logic [7:0] reg_rdata; // read port
	logic irq, sck_out, sck_oe, mosi_out; // link and irq outputs
	logic mosi_oe, miso_out, miso_oe; // remaining link drives
	logic p_sck, p_mosi, p_miso, p_sel_n; // peer drives
	int err_count = 0;
	int n_checks = 0;
	int cycles = 0;
	always #25 core_clk = ~core_clk;
	spi_irq_buffer #(.HALF_DIV(HD), .DIV_W(8)) dut (
		.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_ack(irq_ack),
		.irq(irq), .sck_in(p_sck), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(p_mosi),
		.mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(p_miso), .miso_out(miso_out),
		.miso_oe(miso_oe),
		.sel_n_in(p_sel_n)
	);
	spi_peer u_peer (
		.dut_sck(sck_out), .dut_sck_oe(sck_oe), .dut_mosi(mosi_out), .dut_miso(miso_out),
		.miso(p_miso), .sck(p_sck), .mosi(p_mosi), .sel_n(p_sel_n)
	);
	// compare and count
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// one-cycle write, then an idle cycle
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		@(posedge core_clk);
	endtask
	// read and compare the data of the following cycle
	task automatic rdchk(input logic [2:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		chk($sformatf("reg %0d", a), reg_rdata, e);
		@(posedge core_clk);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// hang guard
	always @(posedge core_clk) begin
		cycles++;
		if (cycles > 5000) begin
			err_count++;
			give_verdict();
		end
	end
	initial begin
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		for (int a = 0; a < 8; a++) rdchk(a[2:0], 8'h00);
		$display("reset values done");
		foreach (rows[i]) begin
			wr(spi_irq_pkg::OFF_CTRL_B, rows[i].b);
			wr(spi_irq_pkg::OFF_IRQ_EN, rows[i].w);
			rdchk(spi_irq_pkg::OFF_IRQ_EN, rows[i].e);
		end
		$display("enable table done");
		// unbuffered master with a collision
		wr(spi_irq_pkg::OFF_CTRL_B, 8'h00);
		wr(spi_irq_pkg::OFF_CTRL_A, 8'h21);
		u_peer.load(8'h3C);
		wr(spi_irq_pkg::OFF_DATA, 8'hA5);
		wr(spi_irq_pkg::OFF_DATA, 8'h5A);
		rdchk(spi_irq_pkg::OFF_IRQ_FLAGS, 8'h40);
		repeat (BYTE) @(posedge core_clk);
		chk("irq", irq, 1'b1);
		chk("mosi oe", mosi_oe, 1'b1);
		rdchk(spi_irq_pkg::OFF_IRQ_FLAGS, 8'hC0);
		chk("peer rx", u_peer.rx_sh, 8'hA5);
		rdchk(spi_irq_pkg::OFF_DATA, 8'h3C);
		rdchk(spi_irq_pkg::OFF_IRQ_FLAGS, 8'h00);
		wr(spi_irq_pkg::OFF_DATA, 8'hC3);
		repeat (BYTE) @(posedge core_clk);
		irq_ack <= 1'b1;
		@(posedge core_clk);
		irq_ack <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk("irq after ack", irq, 1'b0);
		rdchk(spi_irq_pkg::OFF_IRQ_FLAGS, 8'h00);
		rdchk(spi_irq_pkg::OFF_DATA, 8'h5A);
		$display("unbuffered done");
		// buffered: staging, flags, overflow
		wr(spi_irq_pkg::OFF_CTRL_B, 8'h80);
		wr(spi_irq_pkg::OFF_IRQ_EN, 8'hF0);
		rdchk(spi_irq_pkg::OFF_IRQ_FLAGS, 8'h20);
		chk("irq empty", irq, 1'b1);
		wr(spi_irq_pkg::OFF_DATA, 8'h11);
		wr(spi_irq_pkg::OFF_DATA, 8'h22);
		rdchk(spi_irq_pkg::OFF_IRQ_FLAGS, 8'h00);
		repeat (2 * BYTE) @(posedge core_clk);
		rdchk(spi_irq_pkg::OFF_IRQ_FLAGS, 8'hE0);
		wr(spi_irq_pkg::OFF_IRQ_FLAGS, 8'h00);
		rdchk(spi_irq_pkg::OFF_IRQ_FLAGS, 8'hE0);
		wr(spi_irq_pkg::OFF_IRQ_FLAGS, 8'h40);
		rdchk(spi_irq_pkg::OFF_IRQ_FLAGS, 8'hA0);
		wr(spi_irq_pkg::OFF_DATA, 8'h33);
		repeat (BYTE) @(posedge core_clk);
		rdchk(spi_irq_pkg::OFF_IRQ_FLAGS, 8'hE0);
		wr(spi_irq_pkg::OFF_DATA, 8'h44);
		repeat (2) @(posedge core_clk);
		rdchk(spi_irq_pkg::OFF_IRQ_FLAGS, 8'hE1);
		rdchk(spi_irq_pkg::OFF_DATA, 8'h3C);
		rdchk(spi_irq_pkg::OFF_IRQ_FLAGS, 8'hE0);
		rdchk(spi_irq_pkg::OFF_DATA, 8'hEE);
		rdchk(spi_irq_pkg::OFF_IRQ_FLAGS, 8'h60);
		repeat (BYTE) @(posedge core_clk);
		rdchk(spi_irq_pkg::OFF_DATA, 8'hCC);
		$display("buffered done");
		// select pulled low in master role
		wr(spi_irq_pkg::OFF_IRQ_FLAGS, 8'h40);
		u_peer.set_sel(1'b0);
		repeat (8) @(posedge core_clk);
		rdchk(spi_irq_pkg::OFF_IRQ_FLAGS, 8'h30);
		rdchk(spi_irq_pkg::OFF_CTRL_A, 8'h01);
		chk("mosi oe off", mosi_oe, 1'b0);
		chk("miso oe", miso_oe, 1'b1);
		u_peer.set_sel(1'b1);
		wr(spi_irq_pkg::OFF_IRQ_FLAGS, 8'h10);
		rdchk(spi_irq_pkg::OFF_IRQ_FLAGS, 8'h20);
		wr(spi_irq_pkg::OFF_CTRL_B, 8'h84);
		wr(spi_irq_pkg::OFF_CTRL_A, 8'h21);
		u_peer.set_sel(1'b0);
		repeat (8) @(posedge core_clk);
		rdchk(spi_irq_pkg::OFF_CTRL_A, 8'h21);
		rdchk(spi_irq_pkg::OFF_IRQ_FLAGS, 8'h20);
		u_peer.set_sel(1'b1);
		$display("select trigger done");
		// slave role, peer clocks the link
		wr(spi_irq_pkg::OFF_CTRL_B, 8'h00);
		wr(spi_irq_pkg::OFF_CTRL_A, 8'h01);
		wr(spi_irq_pkg::OFF_DATA, 8'h69);
		u_peer.send(8'h96);
		chk("peer miso", u_peer.sl_rx, 8'h69);
		repeat (6) @(posedge core_clk);
		rdchk(spi_irq_pkg::OFF_IRQ_FLAGS, 8'h80);
		rdchk(spi_irq_pkg::OFF_DATA, 8'h96);
		$display("slave role done");
		give_verdict();
	end
endmodule
